// ==== rtl/arb_params.svh ====
// Timing and field constants shared by both ends of the bus arbitration link
`ifndef ARB_PARAMS_SVH
`define ARB_PARAMS_SVH
`define CFG_FLUSH_PIN_BIT      0
`define CFG_INVAL_GRANT_BIT    1
`define CFG_RESET_VALUE        2'h0
`define CPU_EXC_COPROC_ERROR   8'h10
`define SYNC_STAGES            2
`define REQ_MIN_HOLD_CYCLES    4'h4
`define OP_NONE                3'h0
`define OP_WAITING             3'h1
`endif

// ==== rtl/arb_pkg.sv ====
// Types shared by both ends of the bus arbitration link
package arb_pkg;
  typedef enum logic [2:0] {
    cop_none,
    cop_waiting,
    coproc_init_nowait,
    coproc_clear_exc_nowait,
    coproc_store_status_nowait,
    coproc_store_control_nowait,
    coproc_store_env_nowait,
    coproc_save_state_nowait
  } cop_op_t;
  typedef enum {bus_idle, bus_cycle, bus_wait_grant, bus_granted} bus_state_t;
endpackage

// ==== rtl/arb_link_if.sv ====
// Interface joining the processor end and the external master / coprocessor end
`timescale 1ns/100ps
interface arb_link_if;
  logic hold_req;
  logic bus_grant_out;
  logic tristate_all_n;
  logic flush_n;
  logic coproc_error_n;
  logic suspend_ack_n;
  logic suspend_ack_oe;
  logic bus_oe;
  modport cpu (input hold_req, tristate_all_n, flush_n, coproc_error_n,
               output bus_grant_out, suspend_ack_n, suspend_ack_oe, bus_oe);
  modport far (output hold_req, tristate_all_n, flush_n, coproc_error_n,
               input bus_grant_out, suspend_ack_n, suspend_ack_oe, bus_oe);
endinterface

// ==== rtl/in_sync.sv ====
// Two-flop synchroniser bank for asynchronous control inputs
`timescale 1ns/100ps
module in_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] reset_value,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage; reset clears the first stage and loads the resting level on the output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta     <= '0;
      sync_out <= reset_value;
    end else begin
      meta     <= async_in ^ reset_value;
      sync_out <= meta ^ reset_value;
    end
  end
endmodule

// ==== rtl/cpu_bus_hold_float_flush_ctrl.sv ====
// Processor end: hold arbitration, float, cache flush and coprocessor error
`timescale 1ns/100ps
`include "arb_params.svh"
// Operation
// - Coprocessor pulls error low on fault
// - Error sampled only on coprocessor instructions
// - Sampled error raises exception 16
// - Non-waiting store/clear/init ops never raise it
// - Float low tri-states every output
// - Reset required after float changes
// - Flush low invalidates whole cache
// - Flush ignored until enable bit set
// - Invalidate-on-grant bit flushes each hold
// - Finish cycle or locked run, then grant
// - Master drives bus only after grant
// - Bus stays granted while request held
// - Request low: retake bus, drop grant together
// - Hold ignored during reset
// - Reset wins; bus left idle
// - Hold honoured in suspend mode
// - Hold request is level sensitive
// - During grant drive only grant, suspend-ack
// - NMI edge latched in grant; flush still works
module cpu_bus_hold_float_flush_ctrl
  import arb_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    reset,
  arb_link_if.cpu      link,
  input  wire logic    cycle_start,
  input  wire logic    cycle_done,
  input  wire logic    cycle_locked,
  input  wire logic    suspended,
  input  wire logic    suspend_ack_en,
  input  wire logic    suspend_ack_int_n,
  input  wire logic    nmi,
  input  wire logic    cop_op_valid,
  input  wire cop_op_t cop_op,
  input  wire logic    cfg_write,
  input  wire logic [1:0] cfg_wdata,
  output logic [1:0]   config_control_reg0,
  output logic         bus_busy,
  output logic         cache_invalidate,
  output logic         coproc_exc,
  output logic [7:0]   exc_vector,
  output logic         nmi_pending,
  output logic         bus_drive_en
);
  logic [3:0] sync_raw;
  logic       hold_s;
  logic       tristate_s_n;
  logic       flush_s_n;
  logic       err_s_n;
  logic       flush_s_n_d;
  logic       nmi_d;
  logic       floating;
  bus_state_t state;
  bus_state_t next_state;
  logic       next_grant;
  logic       next_drive;
  logic       next_busy;

  // Synchronise all four link inputs; active-low ones rest high
  // Resting levels are loaded in reset, so no false float or flush edge follows it
  in_sync #(.WIDTH(4)) in_sync_inst (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .reset_value (4'he),
    .async_in    ({link.coproc_error_n, link.flush_n, link.tristate_all_n, link.hold_req}),
    .sync_out    (sync_raw)
  );
  assign hold_s       = sync_raw[0];
  assign tristate_s_n = sync_raw[1];
  assign flush_s_n    = sync_raw[2];
  assign err_s_n      = sync_raw[3];
  assign floating     = ~tristate_s_n;

  // Configuration bits, cleared by reset so flush pin starts ignored
  // A write replaces both bits at once; there is no per-bit update
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      config_control_reg0 <= `CFG_RESET_VALUE;
    end else if (cfg_write) begin
      config_control_reg0 <= cfg_wdata;
    end
  end

  // Arbitration: request is a level, re-read every cycle
  always_comb begin
    next_state = state;
    case (state)
      bus_idle: begin
        if (hold_s) begin
          next_state = bus_granted;
        end else if (cycle_start && !suspended) begin
          // A suspended core starts no cycles of its own, yet hold is still served
          next_state = bus_cycle;
        end
      end
      bus_cycle: begin
        // Locked sequences keep the bus until the last cycle ends
        if (cycle_done && !cycle_locked) begin
          next_state = hold_s ? bus_granted : bus_idle;
        end else if (cycle_done && hold_s) begin
          next_state = bus_wait_grant;
        end
      end
      bus_wait_grant: begin
        // Hold came in mid locked run; the run must end before the bus is given up
        if (cycle_done && !cycle_locked) begin
          next_state = hold_s ? bus_granted : bus_idle;
        end
      end
      bus_granted: begin
        // Kept until request drops, suspended or not
        if (!hold_s) begin
          next_state = bus_idle;
        end
      end
      default: next_state = bus_idle;
    endcase
  end

  // Reset wins over hold and leaves the bus idle
  // Hold seen during reset is not looked at; it is re-read from idle afterwards
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= bus_idle;
    end else begin
      state <= next_state;
    end
  end

  // Float overrides the grant but the state machine keeps its place, so a grant
  // cut by float comes back once float is gone; the far end must reset us anyway
  assign next_grant = (next_state == bus_granted) && !floating;
  assign next_drive = (next_state != bus_granted) && !floating;
  assign next_busy  = (next_state == bus_cycle) || (next_state == bus_wait_grant);

  // Grant and bus drive change in the same edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.bus_grant_out <= 1'b0;
      link.bus_oe        <= 1'b0;
      bus_drive_en       <= 1'b0;
      bus_busy           <= 1'b0;
    end else begin
      link.bus_grant_out <= next_grant;
      link.bus_oe        <= next_drive;
      bus_drive_en       <= next_drive;
      bus_busy           <= next_busy;
    end
  end

  // Suspend-ack stays driven through grant, floats on float pin or when suspend_ack_en is low
  // The internal level reaches the pin one cycle late, straight from a flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.suspend_ack_n  <= 1'b1;
      link.suspend_ack_oe <= 1'b0;
    end else begin
      link.suspend_ack_n  <= suspend_ack_int_n;
      link.suspend_ack_oe <= suspend_ack_en && !floating;
    end
  end

  // Flush on pin falling edge when enabled, or on grant entry when the invalidate-on-grant bit is set
  // Edge detect: a pin held low flushes once, not every cycle it stays low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flush_s_n_d      <= 1'b1;
      cache_invalidate <= 1'b0;
    end else begin
      flush_s_n_d      <= flush_s_n;
      cache_invalidate <= (config_control_reg0[`CFG_FLUSH_PIN_BIT] && !flush_s_n
                           && flush_s_n_d)
                          || (config_control_reg0[`CFG_INVAL_GRANT_BIT]
                              && next_state == bus_granted && state != bus_granted);
    end
  end

  // NMI rising edge held while granted, released after request drops
  // Only the rising edge counts; a level left high does not re-arm it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nmi_d       <= 1'b0;
      nmi_pending <= 1'b0;
    end else begin
      nmi_d <= nmi;
      if (nmi && !nmi_d) begin
        nmi_pending <= 1'b1; // Set wins over any clear
      end else if (state != bus_granted) begin
        nmi_pending <= 1'b0;
      end
    end
  end

  // Error checked only at a waiting coprocessor instruction
  // The vector is a constant, but kept in a flop like every other output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      coproc_exc <= 1'b0;
      exc_vector <= 8'h00;
    end else begin
      coproc_exc <= cop_op_valid && (cop_op == cop_waiting) && !err_s_n;
      exc_vector <= `CPU_EXC_COPROC_ERROR;
    end
  end
endmodule

// ==== rtl/arb_far_end.sv ====
// Far end: external bus master and numeric coprocessor pin drivers
`timescale 1ns/100ps
`include "arb_params.svh"
module arb_far_end
  import arb_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  arb_link_if.far   link,
  input  wire logic want_bus,
  input  wire logic float_req,
  input  wire logic flush_req,
  input  wire logic coproc_fault,
  output logic      bus_owned,
  output logic      cpu_reset_req
);
  logic [3:0] held;
  logic       float_d;

  // Request is kept as a level, at least a few cycles, until released
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.hold_req <= 1'b0;
      held          <= 4'h0;
    end else begin
      if (want_bus) begin
        link.hold_req <= 1'b1;
      end else if (held >= `REQ_MIN_HOLD_CYCLES) begin
        link.hold_req <= 1'b0;
      end
      held <= link.hold_req ? (held == 4'hf ? held : held + 4'h1) : 4'h0;
    end
  end

  // Master drives bus only once granted and processor floated
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_owned <= 1'b0;
    end else begin
      bus_owned <= link.hold_req && link.bus_grant_out && !link.bus_oe;
    end
  end

  // Float, flush and coprocessor error pins; error is active low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.tristate_all_n <= 1'b1;
      link.flush_n        <= 1'b1;
      link.coproc_error_n <= 1'b1;
      float_d             <= 1'b0;
      cpu_reset_req       <= 1'b0;
    end else begin
      link.tristate_all_n <= ~float_req;
      link.flush_n        <= ~flush_req;
      link.coproc_error_n <= ~coproc_fault;
      float_d             <= float_req;
      cpu_reset_req       <= float_req ^ float_d; // Reset after each float change
    end
  end
endmodule

// ==== tb/arb_link_sva.sv ====
// Checker for the hold, grant and float signals between the two ends
`timescale 1ns/100ps
module arb_link_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hold_req,
  input wire logic bus_grant_out,
  input wire logic tristate_all_n,
  input wire logic suspend_ack_oe,
  input wire logic bus_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [3:0] fl_run;
  // Cycles since float went away; the synchroniser lag hides the first few
  always_ff @(posedge sys_clk) begin
    if (reset || !tristate_all_n) fl_run <= 4'h0;
    else if (fl_run != 4'hf) fl_run <= fl_run + 4'h1;
  end
  AST_GRANT_BUS_OFF: assert property (bus_grant_out |-> !bus_oe)
    else $error("bus driven while granted");
  AST_DROP_TOGETHER: assert property ($fell(bus_grant_out) && fl_run > 4'h5 |-> bus_oe)
    else $error("bus not retaken with grant drop");
  AST_GRANT_HELD: assert property (
    hold_req [*5] ##0 bus_grant_out && fl_run > 4'h5 |=> bus_grant_out)
    else $error("grant lost while request held");
  AST_RELEASE: assert property (
    $fell(hold_req) && bus_grant_out |-> ##[1:5] !bus_grant_out)
    else $error("grant not dropped after release");
  AST_GRANT_CAUSE: assert property ($rose(bus_grant_out) |-> $past(hold_req, 3))
    else $error("grant without request");
  AST_FLOAT: assert property (
    !tristate_all_n [*4] |=> !bus_grant_out && !bus_oe && !suspend_ack_oe)
    else $error("output driven while floated");
  AST_RESET: assert property (
    disable iff (1'b0) reset |=> !bus_grant_out && !bus_oe)
    else $error("grant or bus driven in reset");
  AST_NO_REQ: assert property (!hold_req [*6] |-> !bus_grant_out)
    else $error("grant without standing request");
  cover property ($rose(bus_grant_out));
  cover property ($fell(bus_grant_out));
  cover property (!tristate_all_n [*4]);
endmodule

// ==== tb/tb_cpu_bus_hold_float_flush_ctrl.sv ====
// Testbench joining the processor end and far end across the link
`timescale 1ns/100ps
module tb_cpu_bus_hold_float_flush_ctrl;
  import arb_pkg::*;
  logic       sys_clk = 0, reset = 1, c_st = 0, c_dn = 0, c_lk = 0, susp = 0, nmi = 0;
  logic       cv = 0, cw = 0, want = 0, flt = 0, fls = 0, err = 0, far_rst = 1, sae = 1;
  logic [1:0] cd = 2'h0, ccr;
  logic [7:0] vec;
  logic       busy, inv, exc, nmip, bde, own, rreq;
  cop_op_t    op = cop_none;
  int         fails = 0, n_checks = 0, k, n_inv = 0, n_exc = 0, n_rr = 0;
  arb_link_if link ();
  cpu_bus_hold_float_flush_ctrl cpu_bus_hold_float_flush_ctrl_inst (.sys_clk(sys_clk),
    .reset(reset), .link(link.cpu), .cycle_start(c_st), .cycle_done(c_dn),
    .cycle_locked(c_lk), .suspended(susp), .suspend_ack_en(sae), .suspend_ack_int_n(1'b0),
    .nmi(nmi), .cop_op_valid(cv), .cop_op(op), .cfg_write(cw), .cfg_wdata(cd),
    .config_control_reg0(ccr), .bus_busy(busy), .cache_invalidate(inv), .coproc_exc(exc),
    .exc_vector(vec), .nmi_pending(nmip), .bus_drive_en(bde));
  // Far end has its own reset so it can request the bus while the processor is in reset
  arb_far_end arb_far_end_inst (.sys_clk(sys_clk), .reset(far_rst), .link(link.far),
    .want_bus(want), .float_req(flt), .flush_req(fls), .coproc_fault(err),
    .bus_owned(own), .cpu_reset_req(rreq));
  arb_link_sva arb_link_sva_inst (.sys_clk(sys_clk), .reset(reset), .hold_req(link.hold_req),
    .bus_grant_out(link.bus_grant_out), .tristate_all_n(link.tristate_all_n),
    .suspend_ack_oe(link.suspend_ack_oe), .bus_oe(link.bus_oe));
  initial forever #25 sys_clk = ~sys_clk;
  // Pulses are counted at the edge, so a check never races the update
  always @(posedge sys_clk) begin
    n_inv += (inv === 1'b1);
    n_exc += (exc === 1'b1);
    n_rr += (rreq === 1'b1);
  end
  task wt(input int n); repeat (n) @(negedge sys_clk); endtask
  task ck(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Bounded wait for grant level; bus enable must be its inverse
  task wg(input logic v);
    int i;
    for (i = 0; i < 12 && link.bus_grant_out !== v; i++) @(negedge sys_clk);
    ck(link.bus_grant_out === v && link.bus_oe === !v, "grant level");
  endtask
  task cfg(input logic [1:0] d); cd = d; cw = 1; wt(1); cw = 0; ck(ccr === d, "cfg"); endtask
  task t_hold;
    cfg(2'h2); susp = 1; k = n_inv; want = 1;
    wg(1);
    wt(10);
    ck(link.bus_grant_out === 1 && link.suspend_ack_oe === 1, "held");
    ck(own === 1 && bde === 0 && link.suspend_ack_n === 0, "master owns bus");
    sae = 0; wt(1);
    ck(link.suspend_ack_oe === 0 && link.bus_grant_out === 1, "suspend ack off");
    sae = 1;
    ck(n_inv == k + 1, "inval on grant");
    nmi = 1; wt(2); ck(nmip === 1, "nmi");
    want = 0; wg(0); nmi = 0; susp = 0;
    ck(own === 0 && bde === 1 && nmip === 1, "bus retaken");
    wt(2); ck(nmip === 0, "nmi released");
    $display("t_hold done");
  endtask
  task t_lock;
    c_st = 1; c_lk = 1; wt(1); c_st = 0; want = 1; wt(8);
    ck(link.bus_grant_out === 0 && busy === 1, "locked run");
    c_dn = 1; wt(1); c_dn = 0; wt(6);
    ck(link.bus_grant_out === 0 && busy === 1, "mid run");
    c_lk = 0; c_dn = 1; wt(1); c_dn = 0; wg(1);
    want = 0; wg(0);
    $display("t_lock done");
  endtask
  task t_flush;
    cfg(2'h0); k = n_inv; fls = 1; wt(8); fls = 0; wt(6);
    ck(n_inv == k, "flush off");
    cfg(2'h1); fls = 1; wt(8); fls = 0; wt(6);
    ck(n_inv == k + 1, "flush");
    want = 1; wg(1); fls = 1; wt(8); fls = 0; wt(6);
    ck(n_inv == k + 2 && link.bus_grant_out === 1, "flush in grant");
    want = 0; wg(0);
    $display("t_flush done");
  endtask
  task t_cop;
    err = 1; wt(4); k = n_exc;
    for (int i = 2; i < 8; i++) begin
      op = cop_op_t'(i); cv = 1; wt(1); cv = 0; wt(2);
    end
    ck(n_exc == k, "nowait op");
    op = cop_waiting; cv = 1; wt(1); cv = 0; wt(2);
    ck(n_exc == k + 1 && vec === 8'h10, "exc 16");
    err = 0; wt(4); cv = 1; wt(1); cv = 0; wt(2); ck(n_exc == k + 1, "no error");
    $display("t_cop done");
  endtask
  task t_rst;
    reset = 1; want = 1; wt(8);
    ck(link.bus_grant_out === 0 && link.bus_oe === 0, "rst");
    ck(busy === 0 && own === 0 && link.hold_req === 1, "idle in reset");
    reset = 0; wg(1); want = 0; wg(0);
    $display("t_rst done");
  endtask
  task t_float;
    k = n_rr; flt = 1; wt(6);
    ck(link.bus_grant_out === 0 && link.bus_oe === 0, "float");
    ck(link.suspend_ack_oe === 0 && bde === 0, "float suspend ack");
    flt = 0; wt(6); ck(n_rr == k + 2, "reset request");
    reset = 1; wt(2); reset = 0; wt(4); ck(link.bus_oe === 1, "after float");
    $display("t_float done");
  endtask
  task summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    wt(4); reset = 0; far_rst = 0; wt(2);
    t_hold; t_lock; t_flush; t_cop; t_rst; t_float;
    summarize;
  end
  // Whole run is under two hundred cycles; this cuts a hang short
  initial begin
    #50000;
    fails++;
    summarize;
  end
endmodule
